// >>> core/error_event_qualifier.sv
// Qualifies raw PCI error indications with configuration enables
`timescale 1ns/1ps
module error_event_qualifier
   import pci_error_pkg::*;
(
   // Configuration
   input wire logic [15:0] config_command_status_in,
   input wire logic host_mode_in,
   // Raw indications
   input wire logic mst_unlocked_pio_in,
   input wire logic tgt_io_access_in,
   input wire logic [1:0] tgt_addr_low_in,
   input wire logic [3:0] tgt_byte_en_n_in,
   input wire logic reread_timeout_in,
   input wire logic master_request_in,
   input wire logic addr_parity_err_in,
   input wire logic serr_asserted_in,
   input wire logic tgt_write_parity_in,
   input wire logic tgt_read_perr_in,
   input wire logic mst_target_abort_in,
   input wire logic mst_master_abort_in,
   input wire logic mst_write_perr_in,
   input wire logic mst_read_parity_in,
   // Qualified events
   output logic illegal_io_out,
   output logic [15:0] events_out
);
   // Enabled bytes may not lie below the byte that the low address bits name
   function automatic logic io_be_illegal(input logic [1:0] a, input logic [3:0] be_n);
      logic [3:0] below;
      below = (4'h1 << a) - 4'h1;
      return (~be_n & below) != 4'h0;
   endfunction

   logic parity_on;
   always_comb begin
      parity_on = config_command_status_in[CFG_PARITY_RESP_EN];
      illegal_io_out = tgt_io_access_in && io_be_illegal(tgt_addr_low_in, tgt_byte_en_n_in);
      events_out = 16'h0000;
      events_out[BIT_UNLOCKED_ACCESS] = mst_unlocked_pio_in; // see RQ9
      events_out[BIT_TGT_ABORT] = illegal_io_out; // see RQ10
      events_out[BIT_REREAD_TIMEOUT] = reread_timeout_in; // see RQ11
      events_out[BIT_MASTER_FORBIDDEN] = master_request_in &&
         !config_command_status_in[CFG_BUS_MASTER_EN]; // see RQ12
      events_out[BIT_ADDR_PARITY] = addr_parity_err_in && parity_on &&
         config_command_status_in[CFG_SYSTEM_ERR_EN]; // see RQ13
      events_out[BIT_SYSTEM_ERROR] = serr_asserted_in && host_mode_in; // see RQ14
      events_out[BIT_TGT_WRITE_PAR] = tgt_write_parity_in && parity_on; // see RQ15
      events_out[BIT_TGT_READ_PERR] = tgt_read_perr_in && parity_on; // see RQ16
      events_out[BIT_MST_TARGET_ABORT] = mst_target_abort_in; // see RQ17
      events_out[BIT_MST_MASTER_ABORT] = mst_master_abort_in; // see RQ17
      events_out[BIT_MST_WRITE_PERR] = mst_write_perr_in && parity_on; // see RQ18
      events_out[BIT_MST_READ_PAR] = mst_read_parity_in && parity_on; // see RQ19
   end
endmodule

// >>> core/pci_error_interrupt_unit.sv
// Error capture, enable mask and local window base for the PCI host bridge
`timescale 1ns/1ps
module pci_error_interrupt_unit
   import pci_error_pkg::*;
#(
   parameter int unsigned REREAD_LIMIT = REREAD_TIMEOUT_CLOCKS
) (
   // Clock and resets
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic soft_rst_in,
   // Internal peripheral bus register port
   input wire logic pp_sel_in,
   input wire logic pp_wr_in,
   input wire logic [1:0] pp_idx_in,
   input wire logic [31:0] pp_wdata_in,
   output logic [31:0] pp_rdata_out,
   output logic pp_rvalid_out,
   // PCI bus register port
   input wire logic pci_sel_in,
   input wire logic pci_wr_in,
   input wire logic [1:0] pci_idx_in,
   input wire logic [31:0] pci_wdata_in,
   output logic [31:0] pci_rdata_out,
   output logic pci_rvalid_out,
   // Configuration
   input wire logic [15:0] config_command_status_in,
   input wire logic host_mode_in,
   // Error indications
   input wire logic mst_unlocked_pio_in,
   input wire logic tgt_io_access_in,
   input wire logic [1:0] tgt_addr_low_in,
   input wire logic [3:0] tgt_byte_en_n_in,
   input wire logic target_reread_timeout_err_issued_in,
   input wire logic tgt_master_repeat_in,
   input wire logic master_request_in,
   input wire logic addr_parity_err_in,
   input wire logic serr_asserted_in,
   input wire logic tgt_write_parity_in,
   input wire logic tgt_read_perr_in,
   input wire logic mst_target_abort_in,
   input wire logic mst_master_abort_in,
   input wire logic mst_write_perr_in,
   input wire logic mst_read_parity_in,
   // Results
   output logic tgt_abort_out,
   output logic [31:0] local_window_base_out,
   output logic error_irq_out
);
   logic [31:0] status_reg;
   logic [31:0] status_next;
   logic [31:0] enable_reg;
   logic [15:0] events;
   logic illegal_io;
   logic reread_timeout;
   logic pp_wr_status;
   logic pci_wr_status;
   logic pp_wr_enable;
   logic pci_wr_enable;
   logic pp_wr_window;
   logic [31:0] clear_mask;
   logic [31:0] kept;
   logic accept;
   logic [15:0] chosen;

   function automatic logic [31:0] reg_read(input logic [1:0] idx, input logic [31:0] win,
                                            input logic [31:0] st, input logic [31:0] en);
      unique case (idx)
         IDX_WINDOW: return win & WINDOW_FIELD_MASK;
         IDX_STATUS: return st & ERROR_BITS_MASK;
         IDX_ENABLE: return en & ERROR_BITS_MASK;
         default: return 32'h00000000;
      endcase
   endfunction

   reread_timeout_counter #(
      .LIMIT(REREAD_LIMIT)
   ) u_reread (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .soft_rst_in(soft_rst_in),
      .retry_issued_in(target_reread_timeout_err_issued_in),
      .master_repeat_in(tgt_master_repeat_in),
      .timeout_out(reread_timeout)
   );

   error_event_qualifier u_qual (
      .config_command_status_in(config_command_status_in),
      .host_mode_in(host_mode_in),
      .mst_unlocked_pio_in(mst_unlocked_pio_in),
      .tgt_io_access_in(tgt_io_access_in),
      .tgt_addr_low_in(tgt_addr_low_in),
      .tgt_byte_en_n_in(tgt_byte_en_n_in),
      .reread_timeout_in(reread_timeout),
      .master_request_in(master_request_in),
      .addr_parity_err_in(addr_parity_err_in),
      .serr_asserted_in(serr_asserted_in),
      .tgt_write_parity_in(tgt_write_parity_in),
      .tgt_read_perr_in(tgt_read_perr_in),
      .mst_target_abort_in(mst_target_abort_in),
      .mst_master_abort_in(mst_master_abort_in),
      .mst_write_perr_in(mst_write_perr_in),
      .mst_read_parity_in(mst_read_parity_in),
      .illegal_io_out(illegal_io),
      .events_out(events)
   );

   always_comb begin
      pp_wr_status = pp_sel_in && pp_wr_in && (pp_idx_in == IDX_STATUS);
      pci_wr_status = pci_sel_in && pci_wr_in && (pci_idx_in == IDX_STATUS);
      pp_wr_enable = pp_sel_in && pp_wr_in && (pp_idx_in == IDX_ENABLE);
      pci_wr_enable = pci_sel_in && pci_wr_in && (pci_idx_in == IDX_ENABLE);
      pp_wr_window = pp_sel_in && pp_wr_in && (pp_idx_in == IDX_WINDOW);
   end

   // Clears from both buses merge; a zero bit clears nothing
   always_comb begin
      clear_mask = ((pp_wr_status ? pp_wdata_in : 32'h0) |
                    (pci_wr_status ? pci_wdata_in : 32'h0)) & ERROR_BITS_MASK; // see RQ5 RQ8
      kept = status_reg & ~clear_mask;
      // Holding is judged after the clear, so an error in the clearing cycle is kept
      accept = (kept == 32'h0); // see RQ7
      chosen = events & (~events + 16'h0001);
      status_next = accept ? (kept | {16'h0000, chosen}) : kept; // see RQ4 RQ6
      status_next = status_next & ERROR_BITS_MASK; // see RQ22
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_reg <= STATUS_RESET;
      end else if (soft_rst_in) begin
         status_reg <= STATUS_RESET; // see RQ3
      end else begin
         status_reg <= status_next;
      end
   end

   // The peripheral bus wins when both buses write the enable in one cycle
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable_reg <= ENABLE_RESET;
      end else if (soft_rst_in) begin
         enable_reg <= ENABLE_RESET; // see RQ21
      end else if (pp_wr_enable) begin
         enable_reg <= pp_wdata_in & ERROR_BITS_MASK; // see RQ21 RQ22
      end else if (pci_wr_enable) begin
         enable_reg <= pci_wdata_in & ERROR_BITS_MASK; // see RQ21 RQ22
      end
   end

   // Window base is writable only from the peripheral bus; PCI sees it read-only
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         local_window_base_out <= WINDOW_RESET;
      end else if (soft_rst_in) begin
         local_window_base_out <= WINDOW_RESET;
      end else if (pp_wr_window) begin
         local_window_base_out <= pp_wdata_in & WINDOW_FIELD_MASK; // see RQ1
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         error_irq_out <= 1'b0;
      end else if (soft_rst_in) begin
         error_irq_out <= 1'b0;
      end else begin
         error_irq_out <= |(status_reg & enable_reg); // see RQ20 RQ23
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tgt_abort_out <= 1'b0;
      end else if (soft_rst_in) begin
         tgt_abort_out <= 1'b0;
      end else begin
         tgt_abort_out <= illegal_io; // see RQ10
      end
   end

   // Read data returns one cycle after the select; it shows the pre-write value
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pp_rdata_out <= 32'h00000000;
         pp_rvalid_out <= 1'b0;
      end else begin
         pp_rvalid_out <= pp_sel_in && !pp_wr_in;
         if (pp_sel_in && !pp_wr_in) begin
            pp_rdata_out <= reg_read(pp_idx_in, local_window_base_out, status_reg, enable_reg); // see RQ8
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pci_rdata_out <= 32'h00000000;
         pci_rvalid_out <= 1'b0;
      end else begin
         pci_rvalid_out <= pci_sel_in && !pci_wr_in;
         if (pci_sel_in && !pci_wr_in) begin
            pci_rdata_out <= reg_read(pci_idx_in, local_window_base_out, status_reg, enable_reg); // see RQ8
         end
      end
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_status_reserved_zero: assert property ((status_reg & ~ERROR_BITS_MASK) == 32'h0) // see RQ22
      else $error("status reserved bit set");
   a_enable_reserved_zero: assert property ((enable_reg & ~ERROR_BITS_MASK) == 32'h0) // see RQ22
      else $error("enable reserved bit set");
   a_window_field_only: assert property ((local_window_base_out & ~WINDOW_FIELD_MASK) == 32'h0) // see RQ1
      else $error("window base holds bits outside 28..20");
   a_single_source_held: assert property ($onehot0(status_reg)) // see RQ7
      else $error("more than one error source held");
   a_error_recorded: assert property (!soft_rst_in && events != 16'h0 && clear_mask == 32'h0 && status_reg == 32'h0
      |=> status_reg != 32'h0) // see RQ4 RQ6
      else $error("detected error not recorded");
   a_w1c_clears_bit: assert property (!soft_rst_in && pp_wr_status && events == 16'h0 && status_reg != 32'h0
      |=> (status_reg & $past(pp_wdata_in)) == 32'h0) // see RQ5
      else $error("write one did not clear status");
   a_zero_write_keeps: assert property (!soft_rst_in && pci_wr_status && pci_wdata_in == 32'h0 && !pp_wr_status
      |=> ($past(status_reg) & ~status_reg) == 32'h0) // see RQ5
      else $error("write zero changed status");
   a_soft_reset_clears: assert property (soft_rst_in |=> status_reg == 32'h0 && enable_reg == 32'h0) // see RQ3 RQ21
      else $error("software reset left state");
   a_irq_from_mask: assert property (!soft_rst_in && (status_reg & enable_reg) != 32'h0 ##1 !soft_rst_in
      |-> error_irq_out) // see RQ20 RQ23
      else $error("enabled error gave no interrupt");
   a_irq_masked_quiet: assert property (enable_reg == 32'h0 ##1 enable_reg == 32'h0 |-> !error_irq_out) // see RQ20
      else $error("interrupt with all enables off");
   a_abort_on_illegal: assert property (!soft_rst_in && illegal_io |=> tgt_abort_out) // see RQ10
      else $error("illegal io access not aborted");
   a_forbidden_master: assert property (!soft_rst_in && master_request_in && !config_command_status_in[CFG_BUS_MASTER_EN]
      && events[7:0] == 8'h00 && status_reg == 32'h0 && clear_mask == 32'h0
      |=> status_reg[BIT_MASTER_FORBIDDEN]) // see RQ12
      else $error("forbidden master op not recorded");

   c_irq_raised: cover property (!error_irq_out ##1 error_irq_out);
   c_target_abort: cover property (tgt_abort_out);
   c_reread_timeout: cover property (reread_timeout);
   c_clear_and_set: cover property (clear_mask != 32'h0 && events != 16'h0);
endmodule

// >>> core/pci_error_pkg.sv
// Constants shared by the PCI error capture and interrupt unit
//Contract
//RQ1 - Window base holds start address bits 28..20; 28..26 area, 25..20 offset.
//RQ2 - Software programs window base before inbound target transfers; reserved bits zero.
//RQ3 - Error status clears to zero on power-on and software reset.
//RQ4 - A detected error sets its matching status bit to 1.
//RQ5 - Writing 1 clears a status bit from either bus; 0 leaves it.
//RQ6 - Status bits set even when the matching enable bit is off.
//RQ7 - Only one error source held; later errors dropped while it stays set.
//RQ8 - Status readable and write-one-clearable from both peripheral and PCI buses.
//RQ9 - Master unlocked PIO to a locked target sets status bit 15.
//RQ10 - Illegal I/O address/byte-enable combination: target abort, set bit 14.
//RQ11 - Retried memory read not repeated within 2^15 clocks sets bit 9.
//RQ12 - Master operation attempted with bus-master enable 0 sets bit 8.
//RQ13 - Address parity error sets bit 7 only when parity and system-error enables set.
//RQ14 - Host seeing SERR# asserted sets bit 6.
//RQ15 - Target write data parity error sets bit 5 when parity response enabled.
//RQ16 - Target read with PERR# observed sets bit 4 when config bit 6 set.
//RQ17 - Master transaction ending target abort sets bit 3, master abort bit 2.
//RQ18 - Master write with target PERR# sets bit 1 when parity response enabled.
//RQ19 - Master read data parity error sets bit 0 when parity response enabled.
//RQ20 - Enable bit 0 disables, 1 enables the interrupt at the same position.
//RQ21 - Enable register read/write from both buses, clears to zero on resets.
//RQ22 - Reserved bits 31..16 and 13..10 read zero; software writes zero.
//RQ23 - Interrupt request asserted while any status bit and its enable are both 1.
package pci_error_pkg;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned IDX_WIDTH = 2;
   localparam logic [1:0] IDX_WINDOW = 2'h0;
   localparam logic [1:0] IDX_STATUS = 2'h1;
   localparam logic [1:0] IDX_ENABLE = 2'h2;
   localparam logic [31:0] WINDOW_RESET = 32'h00000000;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   localparam logic [31:0] ENABLE_RESET = 32'h00000000;
   localparam logic [31:0] WINDOW_FIELD_MASK = 32'h1ff00000;
   localparam logic [31:0] ERROR_BITS_MASK = 32'h0000c3ff;
   localparam int unsigned BIT_MST_READ_PAR = 0;
   localparam int unsigned BIT_MST_WRITE_PERR = 1;
   localparam int unsigned BIT_MST_MASTER_ABORT = 2;
   localparam int unsigned BIT_MST_TARGET_ABORT = 3;
   localparam int unsigned BIT_TGT_READ_PERR = 4;
   localparam int unsigned BIT_TGT_WRITE_PAR = 5;
   localparam int unsigned BIT_SYSTEM_ERROR = 6;
   localparam int unsigned BIT_ADDR_PARITY = 7;
   localparam int unsigned BIT_MASTER_FORBIDDEN = 8;
   localparam int unsigned BIT_REREAD_TIMEOUT = 9;
   localparam int unsigned BIT_TGT_ABORT = 14;
   localparam int unsigned BIT_UNLOCKED_ACCESS = 15;
   localparam int unsigned CFG_BUS_MASTER_EN = 2;
   localparam int unsigned CFG_PARITY_RESP_EN = 6;
   localparam int unsigned CFG_SYSTEM_ERR_EN = 8;
   localparam int unsigned REREAD_TIMEOUT_CLOCKS = 32768;
endpackage

// >>> core/reread_timeout_counter.sv
// Counts PCI clocks from a retried memory read until the master repeats it
`timescale 1ns/1ps
module reread_timeout_counter
   import pci_error_pkg::*;
#(
   parameter int unsigned LIMIT = REREAD_TIMEOUT_CLOCKS
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic soft_rst_in,
   // Retry tracking
   input wire logic retry_issued_in,
   input wire logic master_repeat_in,
   output logic timeout_out
);
   localparam int unsigned CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
   logic [CW-1:0] count_reg;
   logic armed_reg;

   // A new retry wins over a repeat in the same cycle and restarts the count
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_reg <= 1'b0;
         count_reg <= '0;
         timeout_out <= 1'b0;
      end else if (soft_rst_in) begin
         armed_reg <= 1'b0;
         count_reg <= '0;
         timeout_out <= 1'b0;
      end else begin
         timeout_out <= 1'b0;
         if (retry_issued_in) begin
            armed_reg <= 1'b1;
            count_reg <= '0;
         end else if (master_repeat_in) begin
            armed_reg <= 1'b0;
         end else if (armed_reg) begin
            if (count_reg == LAST) begin
               armed_reg <= 1'b0;
               timeout_out <= 1'b1; // see RQ11
            end else begin
               count_reg <= count_reg + CW'(1);
            end
         end
      end
   end
endmodule

// >>> tb/pci_agent_model.sv
// Far-side PCI agents that raise error indications on command
`timescale 1ns/1ps
module pci_agent_model (
   // Clock and command
   input wire logic sys_clk_in,
   input wire logic go_in,
   input wire logic [3:0] kind_in,
   // Indications towards the bridge
   output logic [15:0] event_pulse_out,
   output logic io_access_out,
   output logic [1:0] io_addr_low_out,
   output logic [3:0] io_byte_en_n_out,
   output logic retry_out,
   output logic repeat_out
);
   logic [2:0] wait_reg;
   initial begin
      event_pulse_out = '0;
      io_access_out = 1'b0;
      io_addr_low_out = 2'h1;
      io_byte_en_n_out = 4'he;
      retry_out = 1'b0;
      repeat_out = 1'b0;
      wait_reg = 3'h0;
   end
   // Address and byte enables churn outside a valid I/O cycle, in an illegal mix every cycle until kind 4'hc loads a legal pair
   always @(posedge sys_clk_in) begin
      event_pulse_out <= '0;
      io_access_out <= 1'b0;
      retry_out <= 1'b0;
      repeat_out <= (wait_reg == 3'h1);
      wait_reg <= (wait_reg != 3'h0) ? wait_reg - 3'h1 : 3'h0;
      io_addr_low_out <= ~io_addr_low_out;
      io_byte_en_n_out <= ~io_byte_en_n_out;
      if (go_in) begin
         case (kind_in)
            // Slow master never comes back for the retried read
            4'h9: retry_out <= 1'b1;
            4'ha: begin
               retry_out <= 1'b1;
               wait_reg <= 3'h4;
            end
            4'hb: begin
               io_access_out <= 1'b1;
               io_addr_low_out <= 2'h1;
               io_byte_en_n_out <= 4'he;
            end
            4'hc: begin
               io_access_out <= 1'b1;
               io_addr_low_out <= 2'h0;
               io_byte_en_n_out <= 4'h0;
            end
            default: event_pulse_out[kind_in] <= 1'b1;
         endcase
      end
   end
endmodule

// >>> tb/test_pci_error_interrupt_unit.sv
// Self-checking bench for the PCI error capture and interrupt unit
`timescale 1ns/1ps
module test_pci_error_interrupt_unit;
   import pci_error_pkg::*;
   typedef struct packed {
      logic [3:0] kind;
      logic [15:0] cfg;
      logic host;
      logic [31:0] exp;
   } row_type;
   localparam int LIMIT = 16;
   logic sys_clk_in, rst_n_in, soft_rst_in, pp_sel, pp_wr, pci_sel, pci_wr, host_mode, go;
   logic io_access, retry, repeat_req, pp_rvalid, pci_rvalid, tgt_abort, error_irq;
   logic [1:0] pp_idx, pci_idx, io_addr_low;
   logic [31:0] pp_wdata, pci_wdata, pp_rdata, pci_rdata, window_base;
   logic [15:0] cfg, ev;
   logic [3:0] kind, io_be_n;
   int failures = 0, n_tests = 0, cycles = 0, aborts = 0, seen;
   row_type rows [22];

   pci_error_interrupt_unit #(.REREAD_LIMIT(LIMIT)) uut (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst_in),
      .pp_sel_in(pp_sel), .pp_wr_in(pp_wr), .pp_idx_in(pp_idx), .pp_wdata_in(pp_wdata),
      .pp_rdata_out(pp_rdata), .pp_rvalid_out(pp_rvalid),
      .pci_sel_in(pci_sel), .pci_wr_in(pci_wr), .pci_idx_in(pci_idx), .pci_wdata_in(pci_wdata),
      .pci_rdata_out(pci_rdata), .pci_rvalid_out(pci_rvalid),
      .config_command_status_in(cfg), .host_mode_in(host_mode),
      .mst_unlocked_pio_in(ev[13]), .tgt_io_access_in(io_access), .tgt_addr_low_in(io_addr_low),
      .tgt_byte_en_n_in(io_be_n), .target_reread_timeout_err_issued_in(retry), .tgt_master_repeat_in(repeat_req),
      .master_request_in(ev[8]), .addr_parity_err_in(ev[7]), .serr_asserted_in(ev[6]),
      .tgt_write_parity_in(ev[5]), .tgt_read_perr_in(ev[4]), .mst_target_abort_in(ev[3]),
      .mst_master_abort_in(ev[2]), .mst_write_perr_in(ev[1]), .mst_read_parity_in(ev[0]),
      .tgt_abort_out(tgt_abort), .local_window_base_out(window_base), .error_irq_out(error_irq));

   pci_agent_model far_end (.sys_clk_in(sys_clk_in), .go_in(go), .kind_in(kind), .event_pulse_out(ev),
      .io_access_out(io_access), .io_addr_low_out(io_addr_low), .io_byte_en_n_out(io_be_n),
      .retry_out(retry), .repeat_out(repeat_req));

   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end

   task automatic final_report;
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Run is a little under eight hundred cycles; the ceiling leaves wide margin
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (tgt_abort === 1'b1) aborts <= aborts + 1;
      if (cycles == 5000) begin
         failures = failures + 1;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures = failures + 1;
      end
   endtask

   // A read that brings no valid strobe returns unknown, so it never matches
   task automatic acc(input bit on_pci, input bit wr_en, input logic [1:0] idx, input logic [31:0] wd,
         output logic [31:0] rd_val);
      @(posedge sys_clk_in);
      pp_sel <= !on_pci;
      pci_sel <= on_pci;
      pp_wr <= wr_en;
      pci_wr <= wr_en;
      pp_idx <= idx;
      pci_idx <= idx;
      pp_wdata <= wd;
      pci_wdata <= wd;
      @(posedge sys_clk_in);
      pp_sel <= 1'b0;
      pci_sel <= 1'b0;
      #1;
      if (on_pci) rd_val = (pci_rvalid === 1'b1) ? pci_rdata : 'x;
      else rd_val = (pp_rvalid === 1'b1) ? pp_rdata : 'x;
   endtask

   task automatic wr_reg(input bit on_pci, input logic [1:0] idx, input logic [31:0] wd);
      logic [31:0] unused;
      acc(on_pci, 1'b1, idx, wd, unused);
   endtask

   task automatic rd_reg(input bit on_pci, input logic [1:0] idx, input logic [31:0] exp);
      logic [31:0] got;
      acc(on_pci, 1'b0, idx, 32'h0, got);
      chk(got, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic fire(input logic [3:0] k, input logic [15:0] c, input logic h);
      @(posedge sys_clk_in);
      go <= 1'b1;
      kind <= k;
      cfg <= c;
      host_mode <= h;
      @(posedge sys_clk_in);
      go <= 1'b0;
   endtask

   initial begin
      rows = '{'{4'h0, 16'h0040, 1'b0, 32'h1}, '{4'h0, 16'h0000, 1'b0, 32'h0},
         '{4'h1, 16'h0040, 1'b0, 32'h2}, '{4'h1, 16'h0000, 1'b0, 32'h0},
         '{4'h2, 16'h0000, 1'b0, 32'h4}, '{4'h3, 16'h0000, 1'b0, 32'h8},
         '{4'h4, 16'h0040, 1'b0, 32'h10}, '{4'h4, 16'h0000, 1'b0, 32'h0},
         '{4'h5, 16'h0040, 1'b0, 32'h20}, '{4'h5, 16'h0000, 1'b0, 32'h0},
         '{4'h6, 16'h0000, 1'b1, 32'h40}, '{4'h6, 16'h0000, 1'b0, 32'h0},
         '{4'h7, 16'h0140, 1'b0, 32'h80}, '{4'h7, 16'h0040, 1'b0, 32'h0},
         '{4'h7, 16'h0100, 1'b0, 32'h0}, '{4'h8, 16'h0000, 1'b0, 32'h100},
         '{4'h8, 16'h0004, 1'b0, 32'h0}, '{4'h9, 16'h0000, 1'b0, 32'h200},
         '{4'ha, 16'h0000, 1'b0, 32'h0}, '{4'hb, 16'h0000, 1'b0, 32'h4000},
         '{4'hd, 16'h0000, 1'b0, 32'h8000}, '{4'hc, 16'h0000, 1'b0, 32'h0}};
      {rst_n_in, soft_rst_in, pp_sel, pp_wr, pci_sel, pci_wr, host_mode, go} = 8'h00;
      {pp_idx, pci_idx, pp_wdata, pci_wdata, cfg, kind} = '0;
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      wr_reg(1'b0, 2'h2, 32'h0000c3ff);
      foreach (rows[i]) begin
         wr_reg(i[0], 2'h1, 32'hffffffff);
         idle(2);
         chk({31'h0, error_irq}, 32'h0);
         seen = aborts;
         fire(rows[i].kind, rows[i].cfg, rows[i].host);
         idle(24);
         rd_reg(!i[0], 2'h1, rows[i].exp);
         chk({31'h0, error_irq}, 32'(rows[i].exp != 32'h0));
         chk(32'(aborts - seen), 32'(rows[i].kind == 4'hb));
      end
      // Second error while the first is held
      wr_reg(1'b0, 2'h1, 32'hffffffff);
      fire(4'h2, 16'h0000, 1'b0);
      fire(4'h3, 16'h0000, 1'b0);
      idle(4);
      rd_reg(1'b1, 2'h1, 32'h00000004);
      wr_reg(1'b1, 2'h1, 32'h0000fbfb);
      rd_reg(1'b0, 2'h1, 32'h00000004);
      wr_reg(1'b0, 2'h1, 32'h00000004);
      idle(2);
      rd_reg(1'b1, 2'h1, 32'h0);
      chk({31'h0, error_irq}, 32'h0);
      // Masked error still recorded
      wr_reg(1'b1, 2'h2, 32'h0);
      fire(4'hd, 16'h0000, 1'b0);
      idle(4);
      rd_reg(1'b0, 2'h2, 32'h0);
      rd_reg(1'b0, 2'h1, 32'h00008000);
      chk({31'h0, error_irq}, 32'h0);
      wr_reg(1'b0, 2'h2, 32'h00008000);
      idle(2);
      chk({31'h0, error_irq}, 32'h1);
      // Reserved bits, read-only side and unmapped index
      wr_reg(1'b1, 2'h2, 32'hffffffff);
      rd_reg(1'b0, 2'h2, 32'h0000c3ff);
      wr_reg(1'b0, 2'h0, 32'hffffffff);
      rd_reg(1'b0, 2'h0, 32'h1ff00000);
      wr_reg(1'b1, 2'h0, 32'h0);
      rd_reg(1'b1, 2'h0, 32'h1ff00000);
      wr_reg(1'b0, 2'h0, 32'h1c100000);
      chk(window_base, 32'h1c100000);
      wr_reg(1'b0, 2'h3, 32'hffffffff);
      rd_reg(1'b1, 2'h3, 32'h0);
      // Software reset with status, enable and window all non-zero
      @(posedge sys_clk_in);
      soft_rst_in <= 1'b1;
      @(posedge sys_clk_in);
      soft_rst_in <= 1'b0;
      idle(1);
      chk({31'h0, error_irq}, 32'h0);
      rd_reg(1'b0, 2'h1, 32'h0);
      rd_reg(1'b1, 2'h2, 32'h0);
      rd_reg(1'b0, 2'h0, 32'h0);
      // Power-on reset in mid-run
      wr_reg(1'b0, 2'h2, 32'h0000ffff);
      fire(4'h0, 16'h0040, 1'b0);
      idle(4);
      chk({31'h0, error_irq}, 32'h1);
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      idle(1);
      chk({31'h0, error_irq}, 32'h0);
      rd_reg(1'b1, 2'h1, 32'h0);
      rd_reg(1'b0, 2'h2, 32'h0);
      final_report();
   end
endmodule
